// ### rtl/ccp_pkg.sv
/*
  Constants, register map and carrier types of the dual CAN operating core.
  Assumes two controllers with three transmit buffers each and one system clock.
*/
package ccp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCTRL = 2;
  localparam int NBUF  = 3;

  // ----------------------------------------------------------------
  // Central status registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CTX_ADDR   = 32'he004_0000;
  localparam logic [31:0] CRX_ADDR   = 32'he004_0004;
  localparam logic [31:0] CMISC_ADDR = 32'he004_0008;
  localparam int CTX_TS_LSB   = 0;
  localparam int CTX_TBS_LSB  = 8;
  localparam int CTX_TCS_LSB  = 16;
  localparam int CRX_RS_LSB   = 0;
  localparam int CRX_RB_LSB   = 8;
  localparam int CRX_DOS_LSB  = 16;
  localparam int CMS_ES_LSB   = 0;
  localparam int CMS_BUSY_LSB = 8;

  // ----------------------------------------------------------------
  // Per-controller registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_BASE   = 32'he004_4000;
  localparam logic [31:0] CTRL_STRIDE = 32'h0000_4000;
  localparam logic [7:0]  OFS_MODE    = 8'h00;
  localparam logic [7:0]  OFS_IRQ     = 8'h04;
  localparam logic [7:0]  OFS_IEN     = 8'h08;
  localparam logic [7:0]  OFS_ERRCNT  = 8'h0c;
  localparam logic [7:0]  OFS_EWL     = 8'h10;
  localparam logic [7:0]  OFS_STATE   = 8'h14;
  localparam int MODE_HOLD_BIT = 0;
  localparam int MODE_RANK_BIT = 3;
  localparam int MODE_DOZE_BIT = 4;
  localparam int IRQ_WARN_BIT  = 0;
  localparam int IRQ_WAKE_BIT  = 1;
  localparam int IRQ_FAULT_BIT = 2;
  localparam int ERR_REC_LSB   = 0;
  localparam int ERR_TEC_LSB   = 8;
  localparam int ST_BOFF_BIT   = 0;
  localparam int ST_ES_BIT     = 1;
  localparam int ST_SLEEP_BIT  = 2;
  localparam int ST_RUN_BIT    = 3;
  localparam int ST_TEC_LSB    = 16;

  // ----------------------------------------------------------------
  // Fault confinement figures and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TEC_MAX       = 8'hff;
  localparam logic [7:0] TEC_BOFF_LOAD = 8'h7f;
  localparam logic [7:0] TEC_STEP      = 8'h08;
  localparam logic [7:0] REC_STEP      = 8'h01;
  localparam logic [7:0] RECOVER_LAST  = 8'h7f;
  localparam logic [3:0] BUS_FREE_LAST = 4'ha;
  localparam logic [7:0] EWL_RESET     = 8'h60;
  localparam logic       HOLD_RESET    = 1'b1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_err;
    logic rx_err;
    logic tx_ok;
    logic rx_ok;
    logic bit_tick;
  } ccp_evt_t;

  typedef struct packed {
    logic tx_in_progress;
    logic tx_buffers_free;
    logic tx_all_done;
    logic rx_in_progress;
    logic rx_msg_avail;
    logic rx_overrun;
  } ccp_gsr_t;

  localparam ccp_gsr_t GSR_RESET = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic        en;
    logic [28:0] tx_ident;
    logic [7:0]  rank_field;
  } ccp_txbuf_t;

endpackage

// ### rtl/ccp_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes din is asynchronous to clock; dout changes only when stages two and three agree.
*/
`timescale 1ns/1ps
module ccp_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ccp_sync_st_t;

  ccp_sync_st_t st_r;
  ccp_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.q[i] = st_r.s3[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      st_r <= '{INIT, INIT, INIT, INIT};
    else
      st_r <= st_nxt;
  end

  assign dout = st_r.q;
endmodule

// ### rtl/ccp_tx_arb.sv
/*
  Transmit buffer arbiter of one controller, purely combinational.
  Assumes the caller samples the result just before each message start.
*/
`timescale 1ns/1ps
module ccp_tx_arb (
  // Mode and buffers
  input  wire logic                         tx_rank_mode,
  input  ccp_pkg::ccp_txbuf_t [ccp_pkg::NBUF-1:0] bufs,
  // Result
  output logic                              win_vld,
  output logic [1:0]                        win_idx
);
  import ccp_pkg::*;

  logic [28:0] best;
  logic [28:0] key;

  always_comb
  begin
    best    = '0;
    key     = '0;
    win_vld = 1'b0;
    win_idx = 2'h0;
    for (int i = 0; i < NBUF; i++)
    begin
      key = tx_rank_mode ? {21'h0, bufs[i].rank_field} : bufs[i].tx_ident;
      if (bufs[i].en && (!win_vld || key < best))
      begin
        win_vld = 1'b1;
        win_idx = 2'(i);
        best    = key;
      end
    end
  end
endmodule

// ### rtl/ccp_core.sv
/*
  Dual CAN operating core: fault confinement, bus-off recovery, sleep and wake,
  interrupt grouping, transmit arbitration and central status registers.
  Assumes a protocol engine that supplies error/success pulses, a bit-time tick
  and status levels; software on a plain one-cycle register port.
*/
// Design decision made here: the plain strobed port.
// Contract
// - Count errors up, successes down
// - Overflow past 255 enters bus-off, flags
// - Bus-off loads tx count 127, rx zero
// - After hold release, 128 bus-frees count down
// - Recovery end clears bus-off, raises warn
// - Counter writes only while soft hold
// - Writing 255 to tx count forces bus-off
// - Writing 0-254 clears bus-off, one free
// - Sleep needs doze bit, no irq, idle
// - Doze settable only outside soft hold
// - Dominant bit or doze clear wakes
// - Bus wake waits one bus-free first
// - Doze set while busy wakes at once
// - Three requests; transmit ORs three buffers
// - Other requests and table fault ORed
// - Rank by identifier or rank field
// - Smallest value wins, lowest index ties
// - Choose buffer just before each message
// - Central registers read-only, mirror status
// - Central tx: busy, free, done bits
// - Central rx: busy, avail, overrun bits
// - Central misc bits 0-1 warning limit
// - Central misc bits 8-9 bus activity
`timescale 1ns/1ps
module ccp_core (
  // Clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   sys_rst,
  // Register port
  input  wire logic [31:0]                            reg_addr,
  input  wire logic [31:0]                            reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic      [31:0]                            reg_rdata,
  // Bus receive pins
  input  wire logic [ccp_pkg::NCTRL-1:0]              can_rx_pin,
  // Protocol engine
  input  ccp_pkg::ccp_evt_t [ccp_pkg::NCTRL-1:0]      eng_evt,
  input  ccp_pkg::ccp_gsr_t [ccp_pkg::NCTRL-1:0]      eng_gsr,
  input  wire logic [ccp_pkg::NCTRL-1:0]              msg_start,
  // Transmit buffers
  input  ccp_pkg::ccp_txbuf_t [ccp_pkg::NCTRL-1:0][ccp_pkg::NBUF-1:0] tx_buf,
  input  wire logic [ccp_pkg::NCTRL-1:0][ccp_pkg::NBUF-1:0] tx_buf_irq,
  // Other interrupt sources
  input  wire logic [ccp_pkg::NCTRL-1:0]              rx_irq_in,
  input  wire logic                                   lookup_table_fault,
  // Controller state
  output logic      [ccp_pkg::NCTRL-1:0]              ctrl_run,
  output logic      [ccp_pkg::NCTRL-1:0]              ctrl_sleeping,
  output logic      [ccp_pkg::NCTRL-1:0]              tx_pick_vld,
  output logic      [ccp_pkg::NCTRL-1:0][1:0]         tx_pick_idx,
  // Interrupt requests
  output logic      [ccp_pkg::NCTRL-1:0]              irq_rx,
  output logic      [ccp_pkg::NCTRL-1:0]              irq_tx,
  output logic                                        irq_other
);
  import ccp_pkg::*;

  // ----------------------------------------------------------------
  // Types and decode
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       soft_hold_bit;
    logic       tx_rank_mode;
    logic       doze_request_bit;
    logic       sleeping;
    logic       bus_off_flag;
    logic       hold_free;
    logic       error_limit_flag;
    logic       error_warn_irq;
    logic       wake_flag;
    logic       bus_fault_irq;
    logic       error_warn_irq_en;
    logic       wake_irq_en;
    logic       bus_fault_irq_en;
    logic [7:0] tec;
    logic [7:0] rec;
    logic [7:0] error_warn_limit;
    logic [7:0] rcv_cnt;
    logic [3:0] idle_cnt;
    logic       idle;
    logic       pick_vld;
    logic [1:0] pick_idx;
  } ccp_ctl_t;

  typedef struct packed {
    logic [31:0]                rdata;
    ccp_gsr_t [NCTRL-1:0]       gsr;
  } ccp_top_t;

  function automatic logic ctl_hit(input logic [31:0] addr, input int idx,
                                   input logic [7:0] ofs);
    ctl_hit = (addr == CTRL_BASE + CTRL_STRIDE * 32'(idx) + {24'h0, ofs});
  endfunction

  ccp_ctl_t             st_q [NCTRL];
  logic [NCTRL-1:0]     rx_s;
  logic [NCTRL-1:0]     other_req;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  ccp_sync #(
    .W    (NCTRL),
    .INIT ({NCTRL{1'b1}})
  ) u_rx_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (can_rx_pin),
    .dout    (rx_s)
  );

  // ----------------------------------------------------------------
  // Per-controller core
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCTRL; g++)
  begin : g_ctl
    ccp_ctl_t   st_r;
    ccp_ctl_t   st_nxt;
    logic       win_vld;
    logic [1:0] win_idx;
    logic       bus_free;
    logic       pending;
    logic       boff_enter;
    logic       run;
    logic       w_mode;
    logic       w_irq;
    logic       w_ien;
    logic       w_err;
    logic       w_ewl;
    logic [7:0] w_tec;

    ccp_tx_arb u_arb (
      .tx_rank_mode (st_r.tx_rank_mode),
      .bufs         (tx_buf[g]),
      .win_vld      (win_vld),
      .win_idx      (win_idx)
    );

    assign w_mode = reg_wr && ctl_hit(reg_addr, g, OFS_MODE);
    assign w_irq  = reg_wr && ctl_hit(reg_addr, g, OFS_IRQ);
    assign w_ien  = reg_wr && ctl_hit(reg_addr, g, OFS_IEN);
    assign w_err  = reg_wr && ctl_hit(reg_addr, g, OFS_ERRCNT);
    assign w_ewl  = reg_wr && ctl_hit(reg_addr, g, OFS_EWL);
    assign w_tec  = reg_wdata[ERR_TEC_LSB +: 8];
    assign run    = !st_r.soft_hold_bit && !st_r.bus_off_flag;
    // Eleven recessive bit times in a row
    assign bus_free = eng_evt[g].bit_tick && rx_s[g] && (st_r.idle_cnt == BUS_FREE_LAST);
    assign pending  = other_req[g] || irq_rx[g] || irq_tx[g];

    always_comb
    begin
      st_nxt     = st_r;
      boff_enter = 1'b0;

      // Idle detection restarts after each bus-free
      if (eng_evt[g].bit_tick)
      begin
        if (!rx_s[g])
        begin
          st_nxt.idle_cnt = 4'h0;
          st_nxt.idle     = 1'b0;
        end
        else if (bus_free)
        begin
          st_nxt.idle_cnt = 4'h0;
          st_nxt.idle     = 1'b1;
        end
        else
          st_nxt.idle_cnt = st_r.idle_cnt + 4'h1;
      end

      // Clears first so that hardware sets below win
      if (w_irq)
      begin
        if (reg_wdata[IRQ_WARN_BIT])
          st_nxt.error_warn_irq = 1'b0;
        if (reg_wdata[IRQ_WAKE_BIT])
          st_nxt.wake_flag = 1'b0;
        if (reg_wdata[IRQ_FAULT_BIT])
          st_nxt.bus_fault_irq = 1'b0;
      end
      if (w_ien)
      begin
        st_nxt.error_warn_irq_en = reg_wdata[IRQ_WARN_BIT];
        st_nxt.wake_irq_en       = reg_wdata[IRQ_WAKE_BIT];
        st_nxt.bus_fault_irq_en  = reg_wdata[IRQ_FAULT_BIT];
      end
      if (w_ewl)
        st_nxt.error_warn_limit = reg_wdata[7:0];

      if (w_mode)
      begin
        st_nxt.soft_hold_bit = reg_wdata[MODE_HOLD_BIT];
        st_nxt.tx_rank_mode  = reg_wdata[MODE_RANK_BIT];
        if (!reg_wdata[MODE_DOZE_BIT])
        begin
          st_nxt.doze_request_bit = 1'b0;
          if (st_r.sleeping)
          begin
            st_nxt.sleeping = 1'b0;
            if (st_r.wake_irq_en)
              st_nxt.wake_flag = 1'b1;
          end
        end
        else if (!st_r.soft_hold_bit)
        begin
          // busy or pending wakes at once
          if (pending || !st_r.idle)
          begin
            st_nxt.doze_request_bit = 1'b0;
            if (st_r.wake_irq_en)
              st_nxt.wake_flag = 1'b1;
          end
          else
            st_nxt.doze_request_bit = 1'b1;
        end
      end

      if (st_nxt.doze_request_bit && st_r.doze_request_bit && !st_r.sleeping && !pending && st_r.idle)
        st_nxt.sleeping = 1'b1;
      // dominant bit wakes, then wait for bus-free
      if (st_r.sleeping && !rx_s[g])
      begin
        st_nxt.sleeping         = 1'b0;
        st_nxt.doze_request_bit = 1'b0;
        st_nxt.hold_free        = 1'b1;
        if (st_r.wake_irq_en)
          st_nxt.wake_flag = 1'b1;
      end

      if (run)
      begin
        if (eng_evt[g].tx_err)
        begin
          // no room left above the counter
          if (st_r.tec > TEC_MAX - TEC_STEP)
            boff_enter = 1'b1;
          else
            st_nxt.tec = st_r.tec + TEC_STEP;
        end
        else if (eng_evt[g].tx_ok && st_r.tec != 8'h00)
          st_nxt.tec = st_r.tec - 8'h01;
        if (eng_evt[g].rx_err && st_r.rec != TEC_MAX)
          st_nxt.rec = st_r.rec + REC_STEP;
        else if (eng_evt[g].rx_ok && st_r.rec != 8'h00)
          st_nxt.rec = st_r.rec - 8'h01;
      end

      // counters writable in soft hold only
      if (w_err && st_r.soft_hold_bit)
      begin
        st_nxt.rec = reg_wdata[ERR_REC_LSB +: 8];
        if (w_tec == TEC_MAX)
          boff_enter = 1'b1;
        else
        begin
          st_nxt.tec = w_tec;
          if (st_r.bus_off_flag)
          begin
            st_nxt.bus_off_flag = 1'b0;
            st_nxt.hold_free    = 1'b1;
          end
        end
      end

      if (st_r.bus_off_flag && !st_r.soft_hold_bit && bus_free)
      begin
        st_nxt.rcv_cnt = st_r.rcv_cnt + 8'h01;
        if (st_r.tec != 8'h00)
          st_nxt.tec = st_r.tec - 8'h01;
        if (st_r.rcv_cnt == RECOVER_LAST)
        begin
          st_nxt.bus_off_flag     = 1'b0;
          st_nxt.error_limit_flag = 1'b0;
          st_nxt.tec              = 8'h00;
          if (st_r.error_warn_irq_en)
            st_nxt.error_warn_irq = 1'b1;
        end
      end

      if (st_r.hold_free && run && bus_free)
        st_nxt.hold_free = 1'b0;

      if (boff_enter)
      begin
        st_nxt.bus_off_flag  = 1'b1;
        st_nxt.soft_hold_bit = 1'b1;
        st_nxt.tec           = TEC_BOFF_LOAD;
        st_nxt.rec           = 8'h00;
        st_nxt.rcv_cnt       = 8'h00;
        st_nxt.hold_free     = 1'b0;
        if (st_r.bus_fault_irq_en)
          st_nxt.bus_fault_irq = 1'b1;
        if (st_r.error_warn_irq_en)
          st_nxt.error_warn_irq = 1'b1;
      end

      // Warning level tracks the counters outside bus-off
      if (!st_nxt.bus_off_flag)
        st_nxt.error_limit_flag = (st_nxt.tec >= st_r.error_warn_limit) ||
                                  (st_nxt.rec >= st_r.error_warn_limit);
      else
        st_nxt.error_limit_flag = 1'b1;
      if (st_nxt.error_limit_flag != st_r.error_limit_flag && st_r.error_warn_irq_en)
        st_nxt.error_warn_irq = 1'b1;

      // latch the winner at each message start
      if (msg_start[g])
      begin
        st_nxt.pick_vld = win_vld;
        st_nxt.pick_idx = win_idx;
      end
    end

    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        st_r                  <= '0;
        st_r.soft_hold_bit    <= HOLD_RESET;
        st_r.error_warn_limit <= EWL_RESET;
        st_r.idle             <= 1'b1;
      end
      else
        st_r <= st_nxt;
    end

    assign st_q[g]          = st_r;
    assign ctrl_run[g]      = run && !st_r.hold_free && !st_r.sleeping;
    assign ctrl_sleeping[g] = st_r.sleeping;
    assign tx_pick_vld[g]   = st_r.pick_vld;
    assign tx_pick_idx[g]   = st_r.pick_idx;
    assign irq_rx[g]        = rx_irq_in[g];
    assign irq_tx[g]        = |tx_buf_irq[g];
    assign other_req[g]     = st_r.error_warn_irq || st_r.wake_flag || st_r.bus_fault_irq;
  end
  // one shared line for other status
  assign irq_other = (|other_req) || lookup_table_fault;

  // ----------------------------------------------------------------
  // Register read and central status
  // ----------------------------------------------------------------
  ccp_top_t top_r;
  ccp_top_t top_nxt;

  // Whole word always returned; narrower reads take their lanes from it
  always_comb
  begin
    top_nxt       = top_r;
    top_nxt.gsr   = eng_gsr;
    top_nxt.rdata = 32'h0;
    if (reg_rd)
    begin
      for (int i = 0; i < NCTRL; i++)
      begin
        if (reg_addr == CTX_ADDR)
        begin
          top_nxt.rdata[CTX_TS_LSB + i]  = top_r.gsr[i].tx_in_progress;
          top_nxt.rdata[CTX_TBS_LSB + i] = top_r.gsr[i].tx_buffers_free;
          top_nxt.rdata[CTX_TCS_LSB + i] = top_r.gsr[i].tx_all_done;
        end
        if (reg_addr == CRX_ADDR)
        begin
          top_nxt.rdata[CRX_RS_LSB + i]  = top_r.gsr[i].rx_in_progress;
          top_nxt.rdata[CRX_RB_LSB + i]  = top_r.gsr[i].rx_msg_avail;
          top_nxt.rdata[CRX_DOS_LSB + i] = top_r.gsr[i].rx_overrun;
        end
        if (reg_addr == CMISC_ADDR)
        begin
          top_nxt.rdata[CMS_ES_LSB + i]   = st_q[i].error_limit_flag;
          top_nxt.rdata[CMS_BUSY_LSB + i] = !st_q[i].idle;
        end
        if (ctl_hit(reg_addr, i, OFS_MODE))
        begin
          top_nxt.rdata[MODE_HOLD_BIT] = st_q[i].soft_hold_bit;
          top_nxt.rdata[MODE_RANK_BIT] = st_q[i].tx_rank_mode;
          top_nxt.rdata[MODE_DOZE_BIT] = st_q[i].doze_request_bit;
        end
        if (ctl_hit(reg_addr, i, OFS_IRQ))
        begin
          top_nxt.rdata[IRQ_WARN_BIT]  = st_q[i].error_warn_irq;
          top_nxt.rdata[IRQ_WAKE_BIT]  = st_q[i].wake_flag;
          top_nxt.rdata[IRQ_FAULT_BIT] = st_q[i].bus_fault_irq;
        end
        if (ctl_hit(reg_addr, i, OFS_IEN))
        begin
          top_nxt.rdata[IRQ_WARN_BIT]  = st_q[i].error_warn_irq_en;
          top_nxt.rdata[IRQ_WAKE_BIT]  = st_q[i].wake_irq_en;
          top_nxt.rdata[IRQ_FAULT_BIT] = st_q[i].bus_fault_irq_en;
        end
        if (ctl_hit(reg_addr, i, OFS_ERRCNT))
        begin
          top_nxt.rdata[ERR_REC_LSB +: 8] = st_q[i].rec;
          top_nxt.rdata[ERR_TEC_LSB +: 8] = st_q[i].tec;
        end
        if (ctl_hit(reg_addr, i, OFS_EWL))
          top_nxt.rdata[7:0] = st_q[i].error_warn_limit;
        if (ctl_hit(reg_addr, i, OFS_STATE))
        begin
          top_nxt.rdata[ST_BOFF_BIT]      = st_q[i].bus_off_flag;
          top_nxt.rdata[ST_ES_BIT]        = st_q[i].error_limit_flag;
          top_nxt.rdata[ST_SLEEP_BIT]     = st_q[i].sleeping;
          top_nxt.rdata[ST_RUN_BIT]       = ctrl_run[i];
          top_nxt.rdata[ST_TEC_LSB +: 8]  = st_q[i].tec;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      top_r <= '{32'h0, {NCTRL{GSR_RESET}}};
    else
      top_r <= top_nxt;
  end

  assign reg_rdata = top_r.rdata;
endmodule

// ### sim/ccp_core_assertions.sv
/*
  Port checker of the dual CAN operating core.
  Assumes it is bound to every ccp_core instance.
*/
`timescale 1ns/1ps
module ccp_core_assertions
  import ccp_pkg::*;
(
  // Clock, reset, register port
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic [31:0]           reg_addr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  // Engine and buffers
  input ccp_pkg::ccp_gsr_t [1:0]    eng_gsr,
  input wire logic [1:0]            msg_start,
  input ccp_pkg::ccp_txbuf_t [1:0][2:0] tx_buf,
  input wire logic [1:0][2:0]       tx_buf_irq,
  input wire logic [1:0]            rx_irq_in,
  input wire logic                  lookup_table_fault,
  // Outputs
  input wire logic [1:0]            ctrl_run,
  input wire logic [1:0]            ctrl_sleeping,
  input wire logic [1:0]            tx_pick_vld,
  input wire logic [1:0]            irq_rx,
  input wire logic [1:0]            irq_tx,
  input wire logic                  irq_other
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  rx_irq_pass_a: assert property (irq_rx == rx_irq_in)
    else $error("receive request differs");
  tx_irq_or_a: assert property (irq_tx == {|tx_buf_irq[1], |tx_buf_irq[0]})
    else $error("transmit request is not the buffer OR");
  table_fault_a: assert property (lookup_table_fault |-> irq_other)
    else $error("table fault missing on other request");
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  tx_reserved_a: assert property (reg_rd && reg_addr == CTX_ADDR |=>
    (reg_rdata & 32'hfffc_fcfc) == 32'h0) else $error("central tx reserved bits set");
  rx_mirror_a: assert property (reg_rd && reg_addr == CRX_ADDR |=>
    reg_rdata[9:8] == {$past(eng_gsr[1].rx_msg_avail, 2), $past(eng_gsr[0].rx_msg_avail, 2)})
    else $error("central rx avail bits differ");
  pick_none_a: assert property (msg_start[0] && !(tx_buf[0][0].en || tx_buf[0][1].en
    || tx_buf[0][2].en) |=> !tx_pick_vld[0]) else $error("pick with no buffer enabled");
  sleep_halt_a: assert property (ctrl_sleeping[0] |-> !ctrl_run[0])
    else $error("running while asleep");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 32'he004_000c |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  cover property ($rose(ctrl_sleeping[0]));
  cover property ($fell(ctrl_sleeping[0]));
  cover property (msg_start[0] ##1 tx_pick_vld[0]);
endmodule

bind ccp_core ccp_core_assertions i_chk (.clock(clock), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_gsr(eng_gsr),
  .msg_start(msg_start), .tx_buf(tx_buf), .tx_buf_irq(tx_buf_irq), .rx_irq_in(rx_irq_in),
  .lookup_table_fault(lookup_table_fault), .ctrl_run(ctrl_run),
  .ctrl_sleeping(ctrl_sleeping), .tx_pick_vld(tx_pick_vld), .irq_rx(irq_rx),
  .irq_tx(irq_tx), .irq_other(irq_other));

// ### sim/ccp_bus_node.sv
/*
  Other nodes on the shared bus: recessive unless asked, bit tick every 4 cycles.
  Assumes the bench raises dom_req to show a dominant bit.
*/
`timescale 1ns/1ps
module ccp_bus_node (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Bus
  input  wire logic dom_req,
  output logic      can_rx,
  output logic      bit_tick
);
  logic [1:0] div_r;
  always_ff @(posedge clock)
  begin
    div_r    <= sys_rst ? 2'h0 : div_r + 2'h1;
    bit_tick <= (div_r == 2'h3);
    can_rx   <= !dom_req;
  end
endmodule

// ### sim/ccp_core_tb_top.sv
/*
  Self-checking bench of the dual CAN operating core.
  Assumes ccp_pkg and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module ccp_core_tb_top;
  import ccp_pkg::*;
  localparam logic [31:0] C0 = CTRL_BASE;
  logic [31:0]           reg_addr, reg_wdata, reg_rdata, seed, x;
  logic                  clock, sys_rst, reg_wr, reg_rd, dom_req, lut_r, irq_other, node_rx, tick;
  logic [1:0][3:0]       ev_r;
  logic [1:0]            msg_start, rx_irq_in, ctrl_run, ctrl_sleeping, tx_pick_vld, irq_rx, irq_tx;
  logic [1:0][1:0]       tx_pick_idx;
  logic [1:0][2:0]       tirq_r;
  ccp_gsr_t [1:0]        gsr_r;
  ccp_txbuf_t [1:0][2:0] tb_r;
  int                    failures, n_compared;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

  ccp_bus_node i_node (.clock(clock), .sys_rst(sys_rst), .dom_req(dom_req),
    .can_rx(node_rx), .bit_tick(tick));
  ccp_core i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx_pin({2{node_rx}}),
    .eng_evt({ev_r[1], tick, ev_r[0], tick}), .eng_gsr(gsr_r), .msg_start(msg_start),
    .tx_buf(tb_r), .tx_buf_irq(tirq_r), .rx_irq_in(rx_irq_in), .lookup_table_fault(lut_r),
    .ctrl_run(ctrl_run), .ctrl_sleeping(ctrl_sleeping), .tx_pick_vld(tx_pick_vld),
    .tx_pick_idx(tx_pick_idx), .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_other(irq_other));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Central byte j holds status bit (b-j) of both controllers
  function automatic logic [31:0] cen(input ccp_gsr_t [1:0] g, input int b);
    cen = 32'h0;
    for (int j = 0; j < 3; j++)
      cen[8*j +: 2] = {g[1][b-j], g[0][b-j]};
  endfunction
  function automatic logic [2:0] pick(input logic m, input ccp_txbuf_t [2:0] b);
    logic [28:0] k, best;
    pick = 3'h0;
    best = 29'h0;
    for (int i = 0; i < 3; i++)
    begin
      k = m ? 29'(b[i].rank_field) : b[i].tx_ident;
      if (b[i].en && (!pick[2] || k < best))
      begin
        pick = {1'b1, 2'(i)};
        best = k;
      end
    end
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata & m, e)
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, dom_req, lut_r, ev_r, msg_start} = '0;
    {rx_irq_in, tirq_r, tb_r, failures, n_compared} = '0;
    gsr_r = {2{GSR_RESET}};
    seed = 32'h0fab952a;
    sys_rst = 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd(CTX_ADDR, 32'h0003_0300, '1);
    rd(CMISC_ADDR, 32'h0, '1);
    for (int k = 0; k < 8; k++)
    begin
      x = xs();
      wr(CTX_ADDR, '1);
      gsr_r <= x[11:0];
      rd(CTX_ADDR, cen(x[11:0], 5), '1);
      rd(CRX_ADDR, cen(x[11:0], 2), '1);
    end
    $display("test central done");
    wr(C0 + OFS_IEN, 32'h7);
    wr(C0 + OFS_ERRCNT, 32'hff00);
    rd(C0 + OFS_STATE, 32'h007f_0001, 32'h00ff_0001);
    wr(C0 + OFS_ERRCNT, 32'h6400);
    rd(C0 + OFS_STATE, 32'h0, 32'h1);
    rd(CMISC_ADDR, 32'h1, '1);
    wr(C0 + OFS_ERRCNT, 32'hff00);
    wr(C0 + OFS_MODE, 32'h0);
    wr(C0 + OFS_IRQ, 32'h7);
    // Recovery spans 128 bus-frees of 11 ticks, 4 cycles each
    repeat (5800) @(posedge clock);
    rd(C0 + OFS_STATE, 32'h0, 32'hff0003);
    rd(C0 + OFS_IRQ, 32'h1, 32'h1);
    `CHK(irq_other, 1'b1)
    wr(C0 + OFS_IRQ, 32'h7);
    #1;
    `CHK(irq_other, 1'b0)
    $display("test bus_off done");
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clock);
      ev_r[0] <= k == 5 ? 4'h0 : k < 3 ? 4'h8 : 4'h4;
    end
    rd(C0 + OFS_ERRCNT, 32'h1802, 32'hffff);
    wr(C0 + OFS_ERRCNT, 32'h0);
    rd(C0 + OFS_ERRCNT, 32'h1802, 32'hffff);
    $display("test counting done");
    wr(C0 + OFS_MODE, 32'h10);
    repeat (3) @(posedge clock);
    `CHK(ctrl_sleeping[0], 1'b1)
    dom_req <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK(ctrl_sleeping[0], 1'b0)
    `CHK(ctrl_run[0], 1'b0)
    dom_req <= 1'b0;
    rd(C0 + OFS_IRQ, 32'h2, 32'h2);
    $display("test sleep done");
    for (int k = 0; k < 60; k++)
    begin
      wr(C0 + OFS_MODE, {28'h0, k[0], 3'h0});
      for (int i = 0; i < 6; i++)
      begin
        x = xs();
        tb_r[i/3][i%3] <= '{x[0], 29'(x[2:1]), 8'(x[4:3])};
      end
      {lut_r, rx_irq_in, tirq_r} <= x[17:9];
      msg_start <= 2'h3;
      @(posedge clock);
      msg_start <= 2'h0;
      #1;
      `CHK({tx_pick_vld[0], tx_pick_vld[0] ? tx_pick_idx[0] : 2'h0}, pick(k[0], tb_r[0]))
      `CHK({tx_pick_vld[1], tx_pick_vld[1] ? tx_pick_idx[1] : 2'h0}, pick(1'b0, tb_r[1]))
    end
    $display("test arbiter done");
    end_of_test();
  end
endmodule
